// file: include/qlf_consts.svh
/*
 * Constants of the quat line framer: bus offsets, register fields, reset codes, frame geometry, timing.
 * Assumes a 20 MHz ref_clk; counts are derived from it here.
 */
`ifndef QLF_CONSTS_SVH
`define QLF_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define QLF_CLK_HZ 20000000
`define QLF_QUAT_RATE 80000
`define QLF_QUAT_CYC (`QLF_CLK_HZ / `QLF_QUAT_RATE)
`define QLF_BIT_CYC (`QLF_QUAT_CYC / 2)
`define QLF_TONE_HZ 10000
`define QLF_TONE_HALF_CYC (`QLF_CLK_HZ / (2 * `QLF_TONE_HZ))
`define QLF_TONE_GAP_CYC ((`QLF_TONE_HALF_CYC * 3) / 2)
`define QLF_TONE_EDGES 16
`define QLF_FRAME_US 1500
`define QLF_SYNC_LOSS_MS 480
`define QLF_SYNC_LOSS_FRAMES ((`QLF_SYNC_LOSS_MS * 1000) / `QLF_FRAME_US)

// ----------------------------------------
// frame geometry (bit positions counted from 0)
// ----------------------------------------
`define QLF_FRAME_QUATS 120
`define QLF_FRAME_BITS (2 * `QLF_FRAME_QUATS)
`define QLF_SYNC_QUATS 9
`define QLF_SYNC_BITS (2 * `QLF_SYNC_QUATS)
`define QLF_DATA_LAST 233
`define QLF_OH_FIRST 234
`define QLF_M4_POS 237
`define QLF_M5_POS 238
`define QLF_SF_FRAMES 8
`define QLF_NT_OFFSET_QUATS 60
`define QLF_SIGN_MASK 18'h2AAAA
`define QLF_SCR_LEN 23

// ----------------------------------------
// register map
// ----------------------------------------
`define QLF_REG_CTRL 8'h00
`define QLF_REG_CFG 8'h04
`define QLF_REG_TXOH 8'h08
`define QLF_REG_STATUS 8'h0C
`define QLF_REG_RXOH 8'h10
`define QLF_CTRL_PUP 0
`define QLF_CTRL_PDN 1
`define QLF_CTRL_SRST 2
`define QLF_MODE_SERIAL 2'h0
`define QLF_MODE_GCI_SLAVE 2'h1
`define QLF_MODE_GCI_MASTER 2'h2
`define QLF_CFG_RESET 32'h00000000
`define QLF_TXOH_RESET 32'h000FA000

`endif

// file: include/qlf_pkg.sv
/*
 * Types of the quat line framer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package qlf_pkg;
	typedef enum logic [1:0] {ACT_IDLE, ACT_RUN, ACT_ACTIVE} qlf_act_t;
endpackage

// file: rtl/qlf_line_framer.sv
/*
 * Quat line framer with power control: 2B1Q pairing, 120-quat frames, 8-frame superframes,
 * scrambling, overhead mapping, CRC, sync search and an AHB-Lite register slave.
 * Assumes quats arrive from a timing-recovery front end with a strobe, on pins asynchronous to ref_clk.
 */
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "qlf_consts.svh"

// Summary of operation
// - power-on reset enters power-down, driver off
// - reset loads register defaults, clears activation sequencer
// - registers take defaults; modes set over bus
// - control port works powered up or down
// - serial/GCI slave: power up on command
// - GCI master: data-in low or tone
// - power-down command; registers are kept
// - freeze coefficients after activation then deactivation
// - software reset clears activation sequencer
// - bit pairs become one symbol, no redundancy
// - sign then magnitude; 10=+3,11=+1,01=-1,00=-3
// - frame is 120 quats at 80 kq/s
// - 9-quat marker, user data bits 19-234
// - 8-frame superframe, overhead bits 235-240
// - inverted marker opens superframe, receiver finds it
// - scramble all but marker; descramble received
// - overhead bits 1-3 carry operations channel
// - overhead bit 4 carries flags per frame
// - NT superframe lags by 60 quats
// - CRC covers data and bit 4; febe
module qlf_line_framer #(
	parameter logic [17:0] SYNC_WORD = 18'h3C3C3,
	parameter int SCR_TAP = 5,
	parameter logic [11:0] CRC_POLY = 12'h80F
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic txData,
	output logic txDataReq,
	output logic rxData,
	output logic rxValid,
	input wire logic lineRxSign,
	input wire logic lineRxMag,
	input wire logic lineRxStrobe,
	output logic lineDrvSign,
	output logic lineDrvMag,
	output logic [2:0] lineDrvLevel,
	output logic lineDrvOe,
	input wire logic lineSignalIn,
	output logic lineSignalDetector_n,
	input wire logic serialDataIn,
	output logic masterClkEn,
	output logic coefFreeze
);
	if (SCR_TAP < 1 || SCR_TAP > `QLF_SCR_LEN - 1) begin
		$error("SCR_TAP out of range");
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [4:0] pinMeta_q;
	logic [4:0] pinSync_q;
	logic strobePrev_q;
	logic tonePrev_q;
	always_ff @(posedge ref_clk) begin
		pinMeta_q <= {serialDataIn, lineSignalIn, lineRxStrobe, lineRxMag, lineRxSign};
		pinSync_q <= pinMeta_q;
		strobePrev_q <= pinSync_q[2];
		tonePrev_q <= pinSync_q[3];
	end
	logic quatIn;
	logic toneEdge;
	assign quatIn = pinSync_q[2] & ~strobePrev_q;
	assign toneEdge = pinSync_q[3] ^ tonePrev_q;

	// ----------------------------------------
	// registers and AHB-Lite slave
	// ----------------------------------------
	logic [31:0] cfg_q;
	logic [31:0] txoh_q;
	logic [11:0] rxEoc_q;
	logic [7:0] rxM4_q;
	logic [7:0] aphAddr_q;
	logic aphWrite_q;
	logic aphValid_q;
	logic pupCmd;
	logic pdnCmd;
	logic srstCmd;
	logic wrCtrl;
	logic [31:0] statusWord;
	logic [31:0] rdWord;
	logic aphTake;
	assign aphTake = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wrCtrl = aphValid_q & aphWrite_q & (aphAddr_q == `QLF_REG_CTRL);
	assign pupCmd = wrCtrl & hwdata[`QLF_CTRL_PUP];
	assign pdnCmd = wrCtrl & hwdata[`QLF_CTRL_PDN];
	assign srstCmd = wrCtrl & hwdata[`QLF_CTRL_SRST];

	// address phase is taken regardless of the power state, no wait states ever
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aphValid_q <= 1'b0;
			aphWrite_q <= 1'b0;
			aphAddr_q <= 8'h00;
		end else begin
			aphValid_q <= aphTake;
			aphWrite_q <= hwrite;
			aphAddr_q <= {haddr[7:2], 2'b00};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_q <= `QLF_CFG_RESET;
			txoh_q <= `QLF_TXOH_RESET;
		end else if (aphValid_q && aphWrite_q) begin
			if (aphAddr_q == `QLF_REG_CFG) begin
				cfg_q <= {29'h0, hwdata[2:0]};
			end
			if (aphAddr_q == `QLF_REG_TXOH) begin
				txoh_q <= {12'h0, hwdata[19:0]};
			end
		end
	end

	always_comb begin
		case ({haddr[7:2], 2'b00})
			`QLF_REG_CTRL: rdWord = 32'h00000000;
			`QLF_REG_CFG: rdWord = cfg_q;
			`QLF_REG_TXOH: rdWord = txoh_q;
			`QLF_REG_STATUS: rdWord = statusWord;
			`QLF_REG_RXOH: rdWord = {12'h0, rxM4_q, rxEoc_q};
			default: rdWord = 32'h00000000;
		endcase
	end

	// read data is latched at the address phase so it stands through the data phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (aphTake && !hwrite) begin
			hrdata <= rdWord;
		end
	end

	// ----------------------------------------
	// line signal detector and power control
	// ----------------------------------------
	logic [10:0] toneGap_q;
	logic [4:0] toneEdges_q;
	logic toneSeen;
	logic pwrUp_q;
	logic warm_q;
	qlf_pkg::qlf_act_t act_q;
	logic rxSfLock_q;
	logic rxFrameLock_q;
	logic rxBlockErr_q;
	assign toneSeen = (toneEdges_q == 5'(`QLF_TONE_EDGES));

	// detector stays alive in power-down; edges closer than the gap limit count as tone
	always_ff @(posedge ref_clk) begin
		if (rst || act_q == qlf_pkg::ACT_ACTIVE) begin
			toneGap_q <= 11'h000;
			toneEdges_q <= 5'h00;
		end else if (toneEdge) begin
			toneGap_q <= 11'h000;
			if (!toneSeen) begin
				toneEdges_q <= toneEdges_q + 5'h01;
			end
		end else if (toneGap_q == 11'(`QLF_TONE_GAP_CYC)) begin
			toneEdges_q <= 5'h00;
		end else begin
			toneGap_q <= toneGap_q + 11'h001;
		end
	end

	logic wakeReq;
	always_comb begin
		if (cfg_q[1:0] == `QLF_MODE_GCI_MASTER) begin
			wakeReq = ~pinSync_q[4] | toneSeen;
		end else begin
			wakeReq = pupCmd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwrUp_q <= 1'b0;
		end else if (pdnCmd) begin
			pwrUp_q <= 1'b0;
		end else if (wakeReq) begin
			pwrUp_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || srstCmd) begin
			act_q <= qlf_pkg::ACT_IDLE;
		end else if (!pwrUp_q) begin
			act_q <= qlf_pkg::ACT_IDLE;
		end else begin
			case (act_q)
				qlf_pkg::ACT_IDLE: act_q <= qlf_pkg::ACT_RUN;
				qlf_pkg::ACT_RUN: if (rxSfLock_q) act_q <= qlf_pkg::ACT_ACTIVE;
				qlf_pkg::ACT_ACTIVE: if (!rxFrameLock_q) act_q <= qlf_pkg::ACT_RUN;
				default: act_q <= qlf_pkg::ACT_IDLE;
			endcase
		end
	end

	// coefficients survive power-down only once the loop has been fully up
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			warm_q <= 1'b0;
		end else if (act_q == qlf_pkg::ACT_ACTIVE) begin
			warm_q <= 1'b1;
		end
	end
	assign coefFreeze = warm_q & ~pwrUp_q;
	assign masterClkEn = pwrUp_q;
	assign lineSignalDetector_n = ~(toneSeen & ~pwrUp_q);
	assign statusWord = {25'h0, toneSeen, rxBlockErr_q, warm_q, rxSfLock_q, rxFrameLock_q,
		act_q == qlf_pkg::ACT_ACTIVE, pwrUp_q};

	function automatic logic [11:0] crcStep(input logic [11:0] c, input logic b);
		crcStep = {c[10:0], 1'b0} ^ ((b ^ c[11]) ? CRC_POLY : 12'h000);
	endfunction

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	logic [6:0] bitDiv_q;
	logic [7:0] txPos_q;
	logic [2:0] txFrame_q;
	logic [22:0] txScr_q;
	logic [11:0] txCrc_q;
	logic [11:0] txCrcSend_q;
	logic txSign_q;
	logic txAligned_q;
	logic txBitEn;
	logic txRun;
	logic rxSfStart;
	logic plainBit;
	logic lineBit;
	logic [2:0] ohIdx;
	logic [17:0] txSync;
	logic [3:0] eocIdx;
	logic [3:0] crcIdx;
	logic m4Bit;
	assign txRun = pwrUp_q && act_q != qlf_pkg::ACT_IDLE;
	assign txBitEn = txRun && bitDiv_q == 7'h00;
	assign txDataReq = txBitEn && txPos_q >= 8'(`QLF_SYNC_BITS) && txPos_q <= 8'(`QLF_DATA_LAST);
	assign ohIdx = 3'(txPos_q - 8'(`QLF_OH_FIRST));
	assign txSync = SYNC_WORD ^ (txFrame_q == 3'h0 ? `QLF_SIGN_MASK : 18'h00000);
	assign eocIdx = 4'({2'b00, txFrame_q[1:0]} * 4'h3) + {2'b00, ohIdx[1:0]};
	assign crcIdx = 4'({1'b0, txFrame_q - 3'h2} * 4'h2) + {3'h0, ohIdx[0]};

	always_comb begin
		case (txFrame_q)
			3'h0: m4Bit = txoh_q[12];
			3'h1: m4Bit = cfg_q[2] ? txoh_q[16] : txoh_q[13];
			3'h2: m4Bit = cfg_q[2] ? txoh_q[17] : 1'b1;
			3'h3: m4Bit = cfg_q[2] ? txoh_q[18] : 1'b1;
			3'h4: m4Bit = cfg_q[2] ? txoh_q[19] : 1'b1;
			3'h6: m4Bit = cfg_q[2] ? 1'b1 : txoh_q[14];
			3'h7: m4Bit = cfg_q[2] ? 1'b1 : txoh_q[15];
			default: m4Bit = 1'b1;
		endcase
	end

	always_comb begin
		if (txPos_q < 8'(`QLF_SYNC_BITS)) begin
			plainBit = txSync[5'(17 - txPos_q)];
		end else if (txPos_q <= 8'(`QLF_DATA_LAST)) begin
			plainBit = txData;
		end else if (ohIdx < 3'h3) begin
			plainBit = txoh_q[4'hB - eocIdx];
		end else if (ohIdx == 3'h3) begin
			plainBit = m4Bit;
		end else if (txFrame_q == 3'h0) begin
			plainBit = 1'b1;
		end else if (txFrame_q == 3'h1) begin
			plainBit = ohIdx[0] ? ~rxBlockErr_q : 1'b1;
		end else begin
			plainBit = txCrcSend_q[4'hB - crcIdx];
		end
		lineBit = plainBit;
		if (txPos_q >= 8'(`QLF_SYNC_BITS)) begin
			lineBit = plainBit ^ txScr_q[SCR_TAP - 1] ^ txScr_q[`QLF_SCR_LEN - 1];
		end
	end

	// NT end restarts its frame counters once per activation from the received superframe start
	always_ff @(posedge ref_clk) begin
		if (rst || !txRun) begin
			bitDiv_q <= 7'h00;
			txPos_q <= 8'h00;
			txFrame_q <= 3'h0;
			txAligned_q <= 1'b0;
		end else if (rxSfStart && cfg_q[2] && !txAligned_q) begin
			bitDiv_q <= 7'h00;
			txPos_q <= 8'(`QLF_FRAME_BITS - 2 * (`QLF_NT_OFFSET_QUATS - `QLF_SYNC_QUATS));
			txFrame_q <= 3'h7;
			txAligned_q <= 1'b1;
		end else begin
			bitDiv_q <= (bitDiv_q == 7'(`QLF_BIT_CYC - 1)) ? 7'h00 : bitDiv_q + 7'h01;
			if (txBitEn) begin
				txPos_q <= (txPos_q == 8'(`QLF_FRAME_BITS - 1)) ? 8'h00 : txPos_q + 8'h01;
				if (txPos_q == 8'(`QLF_FRAME_BITS - 1)) begin
					txFrame_q <= txFrame_q + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txScr_q <= 23'h000000;
			txCrc_q <= 12'h000;
			txCrcSend_q <= 12'h000;
		end else if (txBitEn) begin
			if (txPos_q >= 8'(`QLF_SYNC_BITS)) begin
				txScr_q <= {txScr_q[21:0], lineBit};
			end
			if (txFrame_q == 3'h7 && txPos_q == 8'(`QLF_FRAME_BITS - 1)) begin
				txCrcSend_q <= txCrc_q;
				txCrc_q <= 12'h000;
			end else if ((txPos_q >= 8'(`QLF_SYNC_BITS) && txPos_q <= 8'(`QLF_DATA_LAST))
					|| txPos_q == 8'(`QLF_M4_POS)) begin
				txCrc_q <= crcStep(txCrc_q, plainBit);
			end
		end
	end

	// sign bit waits for its magnitude; the pair leaves as one symbol
	// power-down drops the driver in the same cycle as the clock enable
	always_ff @(posedge ref_clk) begin
		if (rst || !txRun || pdnCmd) begin
			txSign_q <= 1'b0;
			lineDrvSign <= 1'b0;
			lineDrvMag <= 1'b0;
			lineDrvLevel <= 3'h0;
			lineDrvOe <= 1'b0;
		end else if (txBitEn) begin
			if (!txPos_q[0]) begin
				txSign_q <= lineBit;
			end else begin
				lineDrvSign <= txSign_q;
				lineDrvMag <= lineBit;
				lineDrvLevel <= txSign_q ? (lineBit ? 3'h1 : 3'h3) : (lineBit ? 3'h7 : 3'h5);
				lineDrvOe <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	logic [1:0] rxPair_q;
	logic [1:0] rxPend_q;
	logic [7:0] rxPos_q;
	logic [2:0] rxFrame_q;
	logic [17:0] rxHist_q;
	logic [22:0] rxScr_q;
	logic [11:0] rxCrc_q;
	logic [11:0] rxCrcPrev_q;
	logic [11:0] rxCrcGot_q;
	logic rxSfValid_q;
	logic [8:0] rxErrs_q;
	logic rxBitEn;
	logic rawBit;
	logic plainRx;
	logic [17:0] histNext;
	logic syncNorm;
	logic syncInv;
	logic syncCheck;
	logic [2:0] rxOh;
	assign rxBitEn = pwrUp_q && rxPend_q != 2'h0;
	assign rawBit = (rxPend_q == 2'h2) ? rxPair_q[1] : rxPair_q[0];
	assign plainRx = rawBit ^ rxScr_q[SCR_TAP - 1] ^ rxScr_q[`QLF_SCR_LEN - 1];
	assign histNext = {rxHist_q[16:0], rawBit};
	assign syncNorm = histNext == SYNC_WORD;
	assign syncInv = histNext == (SYNC_WORD ^ `QLF_SIGN_MASK);
	assign syncCheck = rxBitEn && (rxFrameLock_q ? rxPos_q == 8'(`QLF_SYNC_BITS - 1) : rxPend_q == 2'h1);
	assign rxSfStart = syncCheck && syncInv;
	assign rxOh = 3'(rxPos_q - 8'(`QLF_OH_FIRST));

	always_ff @(posedge ref_clk) begin
		if (rst || !pwrUp_q) begin
			rxPend_q <= 2'h0;
			rxPair_q <= 2'h0;
		end else if (quatIn) begin
			rxPair_q <= {pinSync_q[0], pinSync_q[1]}; // sign goes out first
			rxPend_q <= 2'h2;
		end else if (rxBitEn) begin
			rxPend_q <= rxPend_q - 2'h1;
		end
	end

	// flywheel: lock on first marker, drop after a run of errored markers
	always_ff @(posedge ref_clk) begin
		if (rst || !pwrUp_q || srstCmd) begin
			rxFrameLock_q <= 1'b0;
			rxSfLock_q <= 1'b0;
			rxPos_q <= 8'h00;
			rxFrame_q <= 3'h0;
			rxErrs_q <= 9'h000;
		end else if (rxBitEn) begin
			rxPos_q <= (rxPos_q == 8'(`QLF_FRAME_BITS - 1)) ? 8'h00 : rxPos_q + 8'h01;
			if (rxPos_q == 8'(`QLF_FRAME_BITS - 1)) begin
				rxFrame_q <= rxFrame_q + 3'h1;
			end
			if (syncCheck && (syncNorm || syncInv)) begin
				rxFrameLock_q <= 1'b1;
				rxErrs_q <= 9'h000;
				rxPos_q <= 8'(`QLF_SYNC_BITS);
				if (syncInv) begin
					rxFrame_q <= 3'h0;
					rxSfLock_q <= 1'b1;
				end else if (rxFrame_q == 3'h0) begin
					rxSfLock_q <= 1'b0;
				end
			end else if (syncCheck) begin
				rxErrs_q <= rxErrs_q + 9'h001;
				if (rxErrs_q == 9'(`QLF_SYNC_LOSS_FRAMES - 1)) begin
					rxFrameLock_q <= 1'b0;
					rxSfLock_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxHist_q <= 18'h00000;
			rxScr_q <= 23'h000000;
		end else if (rxBitEn) begin
			rxHist_q <= histNext;
			if (rxFrameLock_q && rxPos_q >= 8'(`QLF_SYNC_BITS)) begin
				rxScr_q <= {rxScr_q[21:0], rawBit};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxData <= 1'b0;
			rxValid <= 1'b0;
		end else begin
			rxValid <= rxBitEn && rxFrameLock_q && rxPos_q >= 8'(`QLF_SYNC_BITS)
				&& rxPos_q <= 8'(`QLF_DATA_LAST);
			if (rxBitEn) begin
				rxData <= plainRx;
			end
		end
	end

	// overhead capture and superframe CRC check; first superframe after lock is not judged
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxEoc_q <= 12'h000;
			rxM4_q <= 8'h00;
			rxCrc_q <= 12'h000;
			rxCrcPrev_q <= 12'h000;
			rxCrcGot_q <= 12'h000;
			rxSfValid_q <= 1'b0;
			rxBlockErr_q <= 1'b0;
		end else if (!rxSfLock_q) begin
			rxSfValid_q <= 1'b0;
			rxCrc_q <= 12'h000;
		end else if (rxBitEn && rxPos_q >= 8'(`QLF_SYNC_BITS)) begin
			if (rxPos_q <= 8'(`QLF_DATA_LAST) || rxPos_q == 8'(`QLF_M4_POS)) begin
				rxCrc_q <= crcStep(rxCrc_q, plainRx);
			end
			if (rxPos_q >= 8'(`QLF_OH_FIRST) && rxOh < 3'h3) begin
				rxEoc_q[4'hB - 4'({2'b00, rxFrame_q[1:0]} * 4'h3) - {2'b00, rxOh[1:0]}] <= plainRx;
			end
			if (rxPos_q == 8'(`QLF_M4_POS)) begin
				rxM4_q[rxFrame_q] <= plainRx;
			end
			if (rxPos_q >= 8'(`QLF_M5_POS) && rxFrame_q >= 3'h2) begin
				rxCrcGot_q[4'hB - 4'({1'b0, rxFrame_q - 3'h2} * 4'h2) - {3'h0, rxOh[0]}] <= plainRx;
			end
			if (rxFrame_q == 3'h7 && rxPos_q == 8'(`QLF_FRAME_BITS - 1)) begin
				rxCrcPrev_q <= rxCrc_q;
				rxCrc_q <= 12'h000;
				rxSfValid_q <= 1'b1;
				rxBlockErr_q <= rxSfValid_q && ({rxCrcGot_q[11:1], plainRx} != rxCrcPrev_q);
			end
		end
	end
endmodule

// file: tb/qlf_line_framer_props.sv
/* Concurrent checks on the quat line framer ports.
 * Assumes a bind onto qlf_line_framer; one clock, rst synchronous active high. */
`timescale 1ns/100ps
module qlf_line_framer_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic txDataReq,
	input wire logic lineDrvSign,
	input wire logic lineDrvMag,
	input wire logic [2:0] lineDrvLevel,
	input wire logic lineDrvOe,
	input wire logic lineSignalDetector_n,
	input wire logic masterClkEn,
	input wire logic coefFreeze
);
	logic [11:0] gapCnt_q;
	logic seenTx_q;
	logic ctrlWr_q;
	// -----
	// helper state
	// -----
	always_ff @(posedge ref_clk) begin
		ctrlWr_q <= !rst && hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h00;
	end
	always_ff @(posedge ref_clk) begin
		// a control write may restart framing, so gap tracking starts over
		if (rst || !masterClkEn || ctrlWr_q)
			seenTx_q <= 1'b0;
		else if (txDataReq)
			seenTx_q <= 1'b1;
	end
	always_ff @(posedge ref_clk) begin
		if (txDataReq)
			gapCnt_q <= 12'h000;
		else if (gapCnt_q != 12'hFFF)
			gapCnt_q <= gapCnt_q + 12'h001;
	end
	// -----
	// properties
	// -----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence pdnWrite;
		hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h00 ##1 hwdata[1];
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_OE_PWR: assert property (lineDrvOe |-> masterClkEn)
		else $error("line driver on while powered down");
	AST_RST_QUIET: assert property ($past(rst) |-> !masterClkEn && !lineDrvOe && lineSignalDetector_n && !coefFreeze)
		else $error("outputs not quiet after reset");
	AST_LEVEL_MAP: assert property (lineDrvOe |-> lineDrvLevel == {~lineDrvSign, lineDrvSign ^ lineDrvMag, 1'b1})
		else $error("quat level does not match sign and magnitude");
	AST_QUAT_HOLD: assert property (masterClkEn && !$past(ctrlWr_q) && $changed({lineDrvSign, lineDrvMag})
		|=> $stable({lineDrvSign, lineDrvMag})[*8])
		else $error("quat changed too soon");
	AST_BIT_GAP: assert property (txDataReq && seenTx_q |-> gapCnt_q == 12'h07C || gapCnt_q == 12'hC34)
		else $error("data bit spacing wrong");
	AST_REQ_PWR: assert property (txDataReq |-> masterClkEn ##1 !txDataReq)
		else $error("data request while down or longer than one cycle");
	AST_LSD_PDN: assert property (!lineSignalDetector_n |-> !masterClkEn)
		else $error("detector output low while powered");
	AST_FREEZE: assert property (coefFreeze |-> !masterClkEn)
		else $error("coefficients frozen while powered");
	AST_PDN_CMD: assert property (pdnWrite |=> !masterClkEn && !lineDrvOe)
		else $error("power-down command not obeyed");
endmodule

// file: tb/qlf_far_end.sv
/* Far-end transceiver model: sends each received quat back with a strobe, and makes the wake-up tone.
 * Assumes 20 MHz ref_clk and a quat every 250 clocks from the near end. */
`timescale 1ns/100ps
module qlf_far_end (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic lineDrvSign,
	input wire logic lineDrvMag,
	input wire logic lineDrvOe,
	input wire logic toneOn,
	output logic lineRxSign,
	output logic lineRxMag,
	output logic lineRxStrobe,
	output logic lineSignalIn
);
	logic [7:0] quatCnt_q;
	logic [9:0] toneCnt_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			quatCnt_q <= 8'h00;
			lineRxStrobe <= 1'b0;
			lineRxSign <= 1'b0;
			lineRxMag <= 1'b1;
		end else if (!lineDrvOe) begin
			// silent line: data wanders, strobe stands still
			quatCnt_q <= 8'h00;
			lineRxStrobe <= 1'b0;
			lineRxSign <= ~lineRxSign;
			lineRxMag <= ~lineRxMag;
		end else begin
			quatCnt_q <= (quatCnt_q == 8'hF9) ? 8'h00 : quatCnt_q + 8'h01;
			if (quatCnt_q == 8'h7D) begin
				lineRxSign <= lineDrvSign;
				lineRxMag <= lineDrvMag;
			end
			// strobe rises well after data settles, for the receiver's synchronisers
			lineRxStrobe <= quatCnt_q >= 8'h81 && quatCnt_q < 8'h8B;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst || !toneOn) begin
			toneCnt_q <= 10'h000;
			lineSignalIn <= 1'b0;
		end else begin
			toneCnt_q <= (toneCnt_q == 10'h3E7) ? 10'h000 : toneCnt_q + 10'h001;
			if (toneCnt_q == 10'h3E7)
				lineSignalIn <= ~lineSignalIn;
		end
	end
endmodule

// file: tb/qlf_line_framer_tb_top.sv
/* Self-checking bench for the quat line framer: AHB-Lite register access, loop-back framing, wake paths.
 * Assumes qlf_far_end and the props checker are compiled before it. */
`timescale 1ns/100ps
module qlf_line_framer_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic txData = 1'b0;
	logic toneOn = 1'b0;
	logic serialDataIn = 1'b1;
	logic lsdSeen = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, txDataReq, rxData, rxValid, lineRxSign, lineRxMag, lineRxStrobe;
	logic lineDrvSign, lineDrvMag, lineDrvOe, lineSignalIn, lineSignalDetector_n, masterClkEn, coefFreeze;
	logic [31:0] hrdata;
	logic [2:0] lineDrvLevel;
	logic [31:0] rstAddr [6] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h10, 32'h14};
	logic [31:0] rstVal [6] = '{32'h0, 32'h0, 32'h000FA000, 32'h0, 32'h0, 32'h0};
	int n_errors = 0;
	int compares = 0;
	int txPos = 0;
	int rxCnt = 0;
	int n;
	always #25 ref_clk = ~ref_clk;
	qlf_line_framer u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .txData(txData), .txDataReq(txDataReq), .rxData(rxData),
		.rxValid(rxValid), .lineRxSign(lineRxSign), .lineRxMag(lineRxMag), .lineRxStrobe(lineRxStrobe),
		.lineDrvSign(lineDrvSign), .lineDrvMag(lineDrvMag), .lineDrvLevel(lineDrvLevel), .lineDrvOe(lineDrvOe),
		.lineSignalIn(lineSignalIn), .lineSignalDetector_n(lineSignalDetector_n),
		.serialDataIn(serialDataIn), .masterClkEn(masterClkEn), .coefFreeze(coefFreeze));
	qlf_far_end u_far (.ref_clk(ref_clk), .rst(rst), .lineDrvSign(lineDrvSign), .lineDrvMag(lineDrvMag),
		.lineDrvOe(lineDrvOe), .toneOn(toneOn), .lineRxSign(lineRxSign), .lineRxMag(lineRxMag),
		.lineRxStrobe(lineRxStrobe), .lineSignalIn(lineSignalIn));
	// -----
	// helpers
	// -----
	function automatic logic pat(input int p);
		return p[0] ^ p[2] ^ p[5];
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do begin
			@(posedge ref_clk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge ref_clk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task tally_and_finish;
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// -----
	// data source and sink
	// -----
	always @(posedge ref_clk) begin
		if (masterClkEn !== 1'b1)
			txPos <= 0;
		else if (txDataReq === 1'b1)
			txPos <= txPos + 1;
		txData <= pat(((txDataReq === 1'b1) ? txPos + 1 : txPos) % 216);
		if (lineSignalDetector_n === 1'b0)
			lsdSeen <= 1'b1;
	end
	// the first received frame is skipped while the descrambler settles
	always @(posedge ref_clk) begin
		if (rxValid === 1'b1) begin
			if (rxCnt >= 216 && rxCnt < 432)
				chk("rxData", {31'h0, pat(rxCnt % 216)}, {31'h0, rxData});
			rxCnt <= rxCnt + 1;
		end
	end
	// -----
	// scenarios
	// -----
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("lineDrvOe", 32'h0, {31'h0, lineDrvOe});
		chk("lineSignalDetector_n", 32'h1, {31'h0, lineSignalDetector_n});
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, rstAddr[i], 32'h0);
			chk("reset read", rstVal[i], rd);
		end
		ahb(1'b1, 32'h00, 32'h3);
		ahb(1'b0, 32'h0C, 32'h0);
		chk("status pup with pdn", 32'h0, {31'h0, rd[0]});
		ahb(1'b1, 32'h04, 32'h1);
		ahb(1'b1, 32'h08, 32'h000FA0C3);
		ahb(1'b0, 32'h04, 32'h0);
		chk("cfg", 32'h1, rd);
		ahb(1'b1, 32'h00, 32'h1);
		ahb(1'b0, 32'h0C, 32'h0);
		chk("status powered", 32'h1, {31'h0, rd[0]});
		n = 0;
		while (rxCnt < 432 && n < 80000) begin
			@(posedge ref_clk);
			n++;
		end
		chk("rx bits", 32'h1, {31'h0, rxCnt >= 432});
		// let the overhead of the second frame arrive; eoc bits 5:0 need later frames
		repeat (1000) @(posedge ref_clk);
		ahb(1'b0, 32'h10, 32'h0);
		chk("rx overhead", 32'h000020C0, {18'h0, rd[13:0]});
		ahb(1'b0, 32'h0C, 32'h0);
		chk("frame lock", 32'h1, {31'h0, rd[2]});
		ahb(1'b1, 32'h00, 32'h4);
		ahb(1'b0, 32'h0C, 32'h0);
		chk("soft reset", 32'h1, {29'h0, rd[2:0]});
		ahb(1'b1, 32'h00, 32'h2);
		ahb(1'b0, 32'h08, 32'h0);
		chk("txoh kept", 32'h000FA0C3, rd);
		chk("coefFreeze", 32'h1, {31'h0, coefFreeze});
		ahb(1'b1, 32'h04, 32'h2);
		ahb(1'b1, 32'h00, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("no command pup in master mode", 32'h0, {31'h0, masterClkEn});
		toneOn <= 1'b1;
		n = 0;
		while (masterClkEn !== 1'b1 && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		chk("tone wake", 32'h1, {31'h0, masterClkEn});
		chk("detector low", 32'h1, {31'h0, lsdSeen});
		toneOn <= 1'b0;
		// the tone detection must lapse, or it would wake the block again at once
		repeat (2000) @(posedge ref_clk);
		ahb(1'b1, 32'h00, 32'h2);
		@(posedge ref_clk);
		chk("pdn in master mode", 32'h0, {31'h0, masterClkEn});
		serialDataIn <= 1'b0;
		n = 0;
		while (masterClkEn !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		chk("data-in wake", 32'h1, {31'h0, masterClkEn});
		serialDataIn <= 1'b1;
		tally_and_finish();
	end
	initial begin
		repeat (95000) @(posedge ref_clk);
		n_errors++;
		tally_and_finish();
	end
endmodule
bind qlf_line_framer qlf_line_framer_props u_props (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.txDataReq(txDataReq), .lineDrvSign(lineDrvSign), .lineDrvMag(lineDrvMag), .lineDrvLevel(lineDrvLevel),
	.lineDrvOe(lineDrvOe), .lineSignalDetector_n(lineSignalDetector_n), .masterClkEn(masterClkEn),
	.coefFreeze(coefFreeze));
